// ==== design/dbgreg_ctrl.sv ====
`timescale 1ns/10ps
module dbgreg_ctrl
    import dbgreg_pkg::*;
#(
    parameter int NUM_HARTS = 1024,
    parameter int NUM_SERIAL = 8,
    parameter logic [4:0] SB_SIZES = 5'h1f,
    parameter bit AUTH_REQ = 1'b0,
    parameter logic [63:0] AUTH_KEY = 64'h0000_0000_1234_5678,
    parameter int SB_TIMEOUT = SB_TIMEOUT_CYC,
    parameter logic [5:0] DRAM_WORDS_M1 = 6'h0f
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire dbgreg_dreq_t dreq,
    output logic drsp_valid,
    output logic [33:0] drsp_data,
    output dbgreg_sbreq_t sb_req,
    input wire logic sb_ready,
    input wire dbgreg_sbrsp_t sb_rsp,
    input wire dbgreg_hev_t clrint,
    input wire dbgreg_hev_t sethalt,
    output logic [NUM_HARTS-1:0] dbg_int,
    output logic ndreset,
    output logic fullreset,
    output logic [NUM_SERIAL-1:0] ser_tx_valid,
    output logic [NUM_SERIAL-1:0][31:0] ser_tx_data,
    input wire logic [NUM_SERIAL-1:0] ser_tx_ready,
    input wire logic [NUM_SERIAL-1:0] ser_rx_valid,
    input wire logic [NUM_SERIAL-1:0][31:0] ser_rx_data,
    output logic [NUM_SERIAL-1:0] ser_rx_ready
);
    if (NUM_HARTS < 1 || NUM_HARTS > 1024 || NUM_SERIAL < 1 ||
        NUM_SERIAL > 8 || SB_TIMEOUT < 1) begin : g_bad
        $error("dbgreg_ctrl: parameter out of range");
    end

    typedef enum logic [1:0] {SB_IDLE, SB_REQ, SB_WAIT} dbgreg_sbst_t;

    logic dm_rst;
    logic auth_ok;
    logic [31:0] auth_hi;
    logic [9:0] hartid;
    logic [2:0] ser_sel;
    logic [2:0] acc;
    logic [2:0] buserr;
    logic ainc;
    logic [95:0] sb_addr;
    logic [127:0] sb_data;
    dbgreg_sbst_t sb_st;
    logic sb_wr;
    logic [31:0] sb_tmr;
    logic rd_v;
    logic rd_w;
    logic [6:0] rd_addr;
    logic rd_int;
    logic rd_halt;
    logic [NUM_HARTS-1:0] int_vec;
    logic [NUM_HARTS-1:0] halt_vec;
    logic [1023:0] halt_pad;
    logic [31:0] hsum;
    logic [NUM_SERIAL-1:0] tx_full;
    logic [NUM_SERIAL-1:0] ovf;
    logic [NUM_SERIAL-1:0] rx_v;
    logic [NUM_SERIAL-1:0][31:0] rx_d;
    logic sel_rv;
    logic sel_full;
    logic [31:0] sel_rd;
    logic wr;
    logic wr_ok;
    logic ctl_wr;
    logic sb_busy;
    logic trig_rd;
    logic trig_wr;
    logic size_ok;
    logic pop;
    logic sb_done;
    logic [9:0] wr_hart;
    logic [31:0] info;

    // a full reset also clears this module one cycle later
    assign dm_rst = rst | fullreset;
    assign wr = dreq.valid & dreq.write;
    assign wr_ok = wr & (auth_ok | dreq.addr == A_AUTH0 |
                         dreq.addr == A_AUTH1);
    assign ctl_wr = wr_ok & dreq.addr == A_CTRL;
    assign wr_hart = dreq.wdata[C_HART_HI:C_HART_LO];
    assign sb_busy = sb_st != SB_IDLE | buserr != ERR_NONE;
    assign trig_rd = wr_ok & dreq.addr == A_SBA0 & !sb_busy;
    assign trig_wr = wr_ok & dreq.addr == A_SBD0 & !sb_busy;
    assign size_ok = (acc <= ACC_MAX) ? SB_SIZES[acc] : 1'b0;
    assign pop = rd_v & !rd_w & rd_addr == A_SDATA & auth_ok;
    assign sb_done = sb_st == SB_WAIT & sb_rsp.valid;
    assign info = {INFO_ABUS, 4'(NUM_SERIAL), SB_SIZES, DRAM_WORDS_M1,
                   1'b1, 1'b0, INFO_VER[3:2], auth_ok, 1'b0,
                   {1'b0, AUTH_REQ}, INFO_VER[1:0]};

    always_ff @(posedge mclk) begin
        if (dm_rst) begin
            auth_ok <= !AUTH_REQ;
            auth_hi <= 32'h0000_0000;
        end else if (ce && AUTH_REQ && wr) begin
            if (dreq.addr == A_AUTH1) auth_hi <= dreq.wdata[31:0];
            if (dreq.addr == A_AUTH0)
                auth_ok <= {auth_hi, dreq.wdata[31:0]} == AUTH_KEY;
        end
    end

    always_ff @(posedge mclk) begin
        if (dm_rst) begin
            hartid <= '0;
            ser_sel <= '0;
            ainc <= 1'b0;
            acc <= ACC_RST;
        end else if (ce && ctl_wr) begin
            hartid <= wr_hart;
            ser_sel <= dreq.wdata[C_SER_HI:C_SER_LO];
            ainc <= dreq.wdata[C_AINC];
            acc <= dreq.wdata[C_ACC_HI:C_ACC_LO];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ndreset <= 1'b0;
            fullreset <= 1'b0;
        end else if (ce) begin
            ndreset <= ctl_wr & dreq.wdata[C_NDRST] & !fullreset;
            fullreset <= ctl_wr & dreq.wdata[C_FULL] & !fullreset;
        end
    end

    // later lines win, so an error arriving with the clear stays
    always_ff @(posedge mclk) begin
        if (dm_rst) begin
            buserr <= ERR_NONE;
        end else if (ce) begin
            if (ctl_wr && !(&dreq.wdata[C_ERR_HI:C_ERR_LO]))
                buserr <= ERR_NONE;
            if ((trig_rd || trig_wr) && !size_ok)
                buserr <= ERR_OTHER;
            if (sb_done && sb_rsp.err != ERR_NONE)
                buserr <= sb_rsp.err;
            if (sb_st == SB_WAIT && !sb_rsp.valid && sb_tmr == '0)
                buserr <= ERR_TIMEOUT;
        end
    end

    always_ff @(posedge mclk) begin
        if (dm_rst) begin
            sb_st <= SB_IDLE;
            sb_wr <= 1'b0;
            sb_tmr <= '0;
        end else if (ce) begin
            case (sb_st)
                SB_IDLE: begin
                    if ((trig_rd || trig_wr) && size_ok) begin
                        sb_st <= SB_REQ;
                        sb_wr <= trig_wr;
                    end
                end
                SB_REQ: begin
                    if (sb_ready && auth_ok) begin
                        sb_st <= SB_WAIT;
                        sb_tmr <= 32'(SB_TIMEOUT - 1);
                    end
                end
                SB_WAIT: begin
                    if (sb_rsp.valid || sb_tmr == '0) sb_st <= SB_IDLE;
                    else sb_tmr <= sb_tmr - 32'h0000_0001;
                end
                default: sb_st <= SB_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (dm_rst) begin
            sb_addr <= '0;
            sb_data <= '0;
        end else if (ce) begin
            if (wr_ok && !sb_busy) begin
                if (dreq.addr == A_SBA0) sb_addr[31:0] <= dreq.wdata[31:0];
                else if (dreq.addr == A_SBA1)
                    sb_addr[63:32] <= dreq.wdata[31:0];
                else if (dreq.addr == A_SBA2)
                    sb_addr[95:64] <= dreq.wdata[31:0];
                else if (dreq.addr == A_SBD0)
                    sb_data[31:0] <= dreq.wdata[31:0];
                else if (dreq.addr == A_SBD1)
                    sb_data[63:32] <= dreq.wdata[31:0];
                else if (dreq.addr == A_SBD2)
                    sb_data[95:64] <= dreq.wdata[31:0];
                else if (dreq.addr == A_SBD3)
                    sb_data[127:96] <= dreq.wdata[31:0];
            end
            if (sb_done && sb_rsp.err == ERR_NONE) begin
                if (!sb_wr) sb_data <= sb_rsp.rdata;
                if (ainc) sb_addr <= sb_addr + (96'h1 << acc);
            end
        end
    end

    always_comb begin
        sb_req.valid = sb_st == SB_REQ && auth_ok;
        sb_req.write = sb_wr;
        sb_req.size = acc;
        sb_req.addr = sb_addr;
        sb_req.wdata = sb_data;
    end

    for (genvar i = 0; i < NUM_SERIAL; i++) begin : g_ser
        logic hit;
        logic full;
        logic of;
        logic rv;
        logic [31:0] td;
        logic [31:0] rd;
        assign hit = wr_ok & dreq.addr == A_SDATA & ser_sel == 3'(i);
        always_ff @(posedge mclk) begin
            if (dm_rst) begin
                full <= 1'b0;
                of <= 1'b0;
                td <= '0;
            end else if (ce) begin
                if (ser_tx_valid[i] && ser_tx_ready[i]) full <= 1'b0;
                if (hit && !dreq.wdata[SD_FULL]) of <= 1'b0;
                if (hit && dreq.wdata[SD_WR]) begin
                    if (full) begin
                        of <= 1'b1;
                    end else begin
                        full <= 1'b1;
                        td <= dreq.wdata[31:0];
                    end
                end
            end
        end
        always_ff @(posedge mclk) begin
            if (dm_rst) begin
                rv <= 1'b0;
                rd <= '0;
            end else if (ce) begin
                if (pop && ser_sel == 3'(i)) rv <= 1'b0;
                if (!rv && ser_rx_valid[i] && auth_ok) begin
                    rv <= 1'b1;
                    rd <= ser_rx_data[i];
                end
            end
        end
        assign tx_full[i] = full;
        assign ovf[i] = of;
        assign rx_v[i] = rv;
        assign rx_d[i] = rd;
        assign ser_tx_data[i] = td;
        assign ser_tx_valid[i] = full & auth_ok;
        assign ser_rx_ready[i] = !rv & auth_ok;
    end

    always_comb begin
        sel_rv = 1'b0;
        sel_full = 1'b0;
        sel_rd = '0;
        if (32'(ser_sel) < NUM_SERIAL) begin
            sel_rv = rx_v[ser_sel];
            sel_full = tx_full[ser_sel] | ovf[ser_sel];
            sel_rd = rx_d[ser_sel];
        end
    end

    always_comb begin
        halt_pad = '0;
        halt_pad[NUM_HARTS-1:0] = halt_vec;
    end

    for (genvar k = 0; k < 32; k++) begin : g_sum
        assign hsum[k] = |halt_pad[32*k +: 32];
    end

    function automatic logic [33:0] rd_mux(input logic [6:0] a);
        logic [33:0] r;
        r = '0;
        if (a == A_CTRL)
            r = {rd_int, rd_halt, 10'h000, buserr, ser_sel, ainc, acc,
                 hartid, 2'b00};
        else if (a == A_INFO) r[31:0] = info;
        else if (a == A_SDATA) r = {sel_rv, sel_full, sel_rd};
        else if (a == A_SSTAT) begin
            r[NUM_SERIAL-1:0] = tx_full | ovf;
            r[SS_RXV +: NUM_SERIAL] = rx_v;
        end
        else if (a == A_SBA0) r[31:0] = sb_addr[31:0];
        else if (a == A_SBA1) r[31:0] = sb_addr[63:32];
        else if (a == A_SBA2) r[31:0] = sb_addr[95:64];
        else if (a == A_SBD0) r[31:0] = sb_data[31:0];
        else if (a == A_SBD1) r[31:0] = sb_data[63:32];
        else if (a == A_SBD2) r[31:0] = sb_data[95:64];
        else if (a == A_SBD3) r[31:0] = sb_data[127:96];
        else if (a == A_HSUM) r[31:0] = hsum;
        else if (a >= A_HST_LO && a <= A_HST_HI)
            r[31:0] = halt_pad[32*(a-A_HST_LO) +: 32];
        return r;
    endfunction : rd_mux

    always_ff @(posedge mclk) begin
        if (dm_rst) begin
            rd_v <= 1'b0;
            rd_w <= 1'b0;
            rd_addr <= '0;
            drsp_valid <= 1'b0;
            drsp_data <= '0;
        end else if (ce) begin
            rd_v <= dreq.valid;
            rd_w <= dreq.write;
            rd_addr <= dreq.addr;
            drsp_valid <= rd_v;
            drsp_data <= (rd_v && !rd_w) ? rd_mux(rd_addr) : '0;
        end
    end

    dbgreg_hartbits #(
        .NUM_HARTS(NUM_HARTS)
    ) u_bits (
        .mclk(mclk),
        .rst(dm_rst),
        .ce(ce),
        .rd_sel(hartid),
        .wr_sel(wr_hart),
        .int_set(ctl_wr & dreq.wdata[C_INT]),
        .halt_clr(ctl_wr & !dreq.wdata[C_HALT]),
        .clr_v(clrint.valid & auth_ok),
        .clr_id(clrint.id),
        .set_v(sethalt.valid & auth_ok),
        .set_id(sethalt.id),
        .int_vec(int_vec),
        .halt_vec(halt_vec),
        .rd_int(rd_int),
        .rd_halt(rd_halt)
    );

    assign dbg_int = auth_ok ? int_vec : '0;

    default clocking cb @(posedge mclk iff ce); endclocking
    default disable iff (dm_rst);

    sequence s_take;
        dreq.valid && !dreq.write && dreq.addr == A_CTRL;
    endsequence
    sequence s_ok_done;
        sb_done && sb_rsp.err == ERR_NONE && ainc;
    endsequence

    property p_gate;
        !auth_ok |-> !sb_req.valid && dbg_int == '0 &&
            ser_tx_valid == '0 && ser_rx_ready == '0;
    endproperty
    a_gate: assert property (p_gate)
        else $error("platform touched while not authenticated");

    property p_rsv;
        s_take |-> ##2 drsp_valid && drsp_data[31:22] == 10'h000;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("control reserved bits not zero");

    property p_err_hold;
        buserr != ERR_NONE && !ctl_wr |=> buserr == $past(buserr);
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("bus error changed without clear");

    property p_err_refuse;
        buserr != ERR_NONE && wr && dreq.addr == A_SBD0
            |=> sb_st == SB_IDLE && sb_data == $past(sb_data);
    endproperty
    a_err_refuse: assert property (p_err_refuse)
        else $error("bus access taken while error set");

    property p_ainc;
        s_ok_done |=> sb_addr == $past(sb_addr) + (96'h1 << $past(acc));
    endproperty
    a_ainc: assert property (p_ainc)
        else $error("address not advanced by access size");

    property p_badsize;
        (trig_rd || trig_wr) && !size_ok
            |=> buserr == ERR_OTHER && sb_st == SB_IDLE;
    endproperty
    a_badsize: assert property (p_badsize)
        else $error("unsupported size not refused");

    property p_ndrst;
        ctl_wr && dreq.wdata[C_NDRST] && !fullreset |=> ndreset;
    endproperty
    a_ndrst: assert property (p_ndrst)
        else $error("non-debug reset pulse missing");

    property p_full;
        @(posedge mclk iff ce) disable iff (rst)
        ctl_wr && dreq.wdata[C_FULL] && !fullreset
            |=> fullreset ##1 hartid == '0 && acc == ACC_RST;
    endproperty
    a_full: assert property (p_full)
        else $error("full reset did not reset the module");

    property p_push;
        wr_ok && dreq.addr == A_SDATA && dreq.wdata[SD_WR] &&
            32'(ser_sel) < NUM_SERIAL && !tx_full[ser_sel]
            |=> tx_full[$past(ser_sel)];
    endproperty
    a_push: assert property (p_push)
        else $error("serial word not queued on selected port");
endmodule : dbgreg_ctrl

// ==== design/dbgreg_pkg.sv ====
package dbgreg_pkg;
    localparam logic [6:0] A_CTRL = 7'h10;
    localparam logic [6:0] A_INFO = 7'h11;
    localparam logic [6:0] A_AUTH0 = 7'h12;
    localparam logic [6:0] A_AUTH1 = 7'h13;
    localparam logic [6:0] A_SDATA = 7'h14;
    localparam logic [6:0] A_SSTAT = 7'h15;
    localparam logic [6:0] A_SBA0 = 7'h16;
    localparam logic [6:0] A_SBA1 = 7'h17;
    localparam logic [6:0] A_SBD0 = 7'h18;
    localparam logic [6:0] A_SBD1 = 7'h19;
    localparam logic [6:0] A_HSUM = 7'h1b;
    localparam logic [6:0] A_HST_LO = 7'h1c;
    localparam logic [6:0] A_HST_HI = 7'h3b;
    localparam logic [6:0] A_SBA2 = 7'h3d;
    localparam logic [6:0] A_SBD2 = 7'h3e;
    localparam logic [6:0] A_SBD3 = 7'h3f;
    localparam int C_INT = 33;
    localparam int C_HALT = 32;
    localparam int C_ERR_HI = 21;
    localparam int C_ERR_LO = 19;
    localparam int C_SER_HI = 18;
    localparam int C_SER_LO = 16;
    localparam int C_AINC = 15;
    localparam int C_ACC_HI = 14;
    localparam int C_ACC_LO = 12;
    localparam int C_HART_HI = 11;
    localparam int C_HART_LO = 2;
    localparam int C_NDRST = 1;
    localparam int C_FULL = 0;
    localparam int SD_WR = 33;
    localparam int SD_FULL = 32;
    localparam int SS_RXV = 8;
    localparam logic [2:0] ACC_RST = 3'h2;
    localparam logic [2:0] ACC_MAX = 3'h4;
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_TIMEOUT = 3'h1;
    localparam logic [2:0] ERR_BADADDR = 3'h2;
    localparam logic [2:0] ERR_OTHER = 3'h3;
    localparam logic [6:0] INFO_ABUS = 7'h60;
    localparam logic [3:0] INFO_VER = 4'h1;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SB_TIMEOUT_NS = 2000;
    localparam int SB_TIMEOUT_CYC = SB_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic valid;
        logic write;
        logic [6:0] addr;
        logic [33:0] wdata;
    } dbgreg_dreq_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] size;
        logic [95:0] addr;
        logic [127:0] wdata;
    } dbgreg_sbreq_t;

    typedef struct packed {
        logic valid;
        logic [2:0] err;
        logic [127:0] rdata;
    } dbgreg_sbrsp_t;

    typedef struct packed {
        logic valid;
        logic [9:0] id;
    } dbgreg_hev_t;
endpackage : dbgreg_pkg

// ==== design/dbgreg_hartbits.sv ====
`timescale 1ns/10ps
module dbgreg_hartbits
    import dbgreg_pkg::*;
#(
    parameter int NUM_HARTS = 1024
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [9:0] rd_sel,
    input wire logic [9:0] wr_sel,
    input wire logic int_set,
    input wire logic halt_clr,
    input wire logic clr_v,
    input wire logic [9:0] clr_id,
    input wire logic set_v,
    input wire logic [9:0] set_id,
    output logic [NUM_HARTS-1:0] int_vec,
    output logic [NUM_HARTS-1:0] halt_vec,
    output logic rd_int,
    output logic rd_halt
);
    function automatic logic bit_at(input logic [NUM_HARTS-1:0] v,
                                    input logic [9:0] s);
        return (s < NUM_HARTS) ? v[s] : 1'b0;
    endfunction : bit_at

    // clears come first so that a set in the same cycle wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            int_vec <= '0;
            halt_vec <= '0;
        end else if (ce) begin
            for (int h = 0; h < NUM_HARTS; h++) begin
                if (clr_v && clr_id == 10'(h)) int_vec[h] <= 1'b0;
                if (int_set && wr_sel == 10'(h)) int_vec[h] <= 1'b1;
                if (halt_clr && wr_sel == 10'(h)) halt_vec[h] <= 1'b0;
                if (set_v && set_id == 10'(h)) halt_vec[h] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_int <= 1'b0;
            rd_halt <= 1'b0;
        end else if (ce) begin
            rd_int <= bit_at(int_vec, rd_sel);
            rd_halt <= bit_at(halt_vec, rd_sel);
        end
    end

    default clocking cb @(posedge mclk iff ce); endclocking
    default disable iff (rst);

    property p_int_set_wins;
        int_set && clr_v && clr_id == wr_sel && wr_sel < NUM_HARTS
            |=> int_vec[$past(wr_sel)];
    endproperty
    a_int_set_wins: assert property (p_int_set_wins)
        else $error("interrupt set lost against clear");

    property p_halt_clr;
        halt_clr && !(set_v && set_id == wr_sel) && wr_sel < NUM_HARTS
            |=> !halt_vec[$past(wr_sel)];
    endproperty
    a_halt_clr: assert property (p_halt_clr)
        else $error("halt notification not cleared");
endmodule : dbgreg_hartbits

// ==== verification/dbgreg_sbus_model.sv ====
`timescale 1ns/10ps
module dbgreg_sbus_model
    import dbgreg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire dbgreg_sbreq_t sb_req,
    input wire logic [2:0] err_code,
    input wire logic mute,
    input wire logic [3:0] lat,
    output logic sb_ready,
    output dbgreg_sbrsp_t sb_rsp,
    output logic [95:0] last_addr
);
    logic busy;
    logic [3:0] cnt;
    assign sb_ready = sb_req.valid && !busy;
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            sb_rsp <= '0;
            last_addr <= '0;
        end else begin
            sb_rsp.valid <= 1'b0;
            // data lines toggle between answers, never hold stale data
            sb_rsp.rdata <= ~sb_rsp.rdata;
            if (sb_ready) begin
                busy <= 1'b1;
                cnt <= lat;
                last_addr <= sb_req.addr;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy && !mute) begin
                busy <= 1'b0;
                sb_rsp.valid <= 1'b1;
                sb_rsp.err <= err_code;
                sb_rsp.rdata <= {4{32'hc0de_0000 ^ last_addr[31:0]}};
            end
        end
    end
endmodule : dbgreg_sbus_model

// ==== verification/dbgreg_ctrl_tb.sv ====
`timescale 1ns/10ps
module dbgreg_ctrl_tb;
    import dbgreg_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    dbgreg_dreq_t dreq = '0;
    dbgreg_hev_t clrint = '0;
    dbgreg_hev_t sethalt = '0;
    logic drsp_valid;
    logic [33:0] drsp_data;
    logic [33:0] rd;
    dbgreg_sbreq_t sb_req;
    logic sb_ready;
    dbgreg_sbrsp_t sb_rsp;
    logic [1023:0] dbg_int;
    logic ndreset;
    logic fullreset;
    logic [7:0] tx_v;
    logic [7:0][31:0] tx_d;
    logic [2:0] err_code = 3'h0;
    logic mute = 1'b0;
    logic [95:0] last_addr;
    int fail_count = 0;
    int total_checks = 0;
    int nd_seen = 0;
    int fr_seen = 0;
    logic [7:0] tx_rdy = 8'h00;
    logic [7:0] rx_v = 8'h00;
    logic [31:0] rx_w = 32'h0000_0000;
    logic [7:0] rx_rdy;
    logic [33:0] lock_data;
    dbgreg_sbreq_t lock_req;
    logic [1023:0] lock_int;
    logic lock_nd;
    logic lock_fr;
    logic [7:0] lock_txv;
    logic [7:0] lock_rxr;
    int lock_seen = 0;

    dbgreg_ctrl #(.SB_TIMEOUT(10)) uut (
        .mclk(mclk), .rst(rst), .ce(1'b1), .dreq(dreq),
        .drsp_valid(drsp_valid), .drsp_data(drsp_data),
        .sb_req(sb_req), .sb_ready(sb_ready), .sb_rsp(sb_rsp),
        .clrint(clrint), .sethalt(sethalt), .dbg_int(dbg_int),
        .ndreset(ndreset), .fullreset(fullreset),
        .ser_tx_valid(tx_v), .ser_tx_data(tx_d), .ser_tx_ready(tx_rdy),
        .ser_rx_valid(rx_v), .ser_rx_data({8{rx_w}}), .ser_rx_ready(rx_rdy)
    );
    // second copy that needs a password and is never unlocked until the end
    dbgreg_ctrl #(.AUTH_REQ(1'b1), .AUTH_KEY(64'h0000_0001_0000_0002))
        uut_lock (
        .mclk(mclk), .rst(rst), .ce(1'b1), .dreq(dreq),
        .drsp_valid(), .drsp_data(lock_data),
        .sb_req(lock_req), .sb_ready(sb_ready), .sb_rsp(sb_rsp),
        .clrint(clrint), .sethalt(sethalt), .dbg_int(lock_int),
        .ndreset(lock_nd), .fullreset(lock_fr),
        .ser_tx_valid(lock_txv), .ser_tx_data(), .ser_tx_ready(tx_rdy),
        .ser_rx_valid(rx_v), .ser_rx_data({8{rx_w}}),
        .ser_rx_ready(lock_rxr)
    );
    dbgreg_sbus_model sbm (
        .mclk(mclk), .rst(rst), .sb_req(sb_req), .err_code(err_code),
        .mute(mute), .lat(4'h6), .sb_ready(sb_ready), .sb_rsp(sb_rsp),
        .last_addr(last_addr)
    );

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic xfer(input logic w, input logic [6:0] a,
                        input logic [33:0] d);
        @(posedge mclk) #1 dreq = '{1'b1, w, a, d};
        @(posedge mclk) #1 dreq.valid = 1'b0;
        for (int i = 0; i < 4 && drsp_valid !== 1'b1; i++)
            @(posedge mclk) #1;
        check(drsp_valid, 1'b1);
        rd = drsp_data;
    endtask : xfer

    task automatic wait_sb;
        for (int i = 0; i < 40 && sb_rsp.valid !== 1'b1; i++)
            @(posedge mclk) #1;
        check(sb_rsp.valid, 1'b1);
        repeat (2) @(posedge mclk) #1;
    endtask : wait_sb

    function automatic logic [33:0] ctl(logic i, logic h, logic [2:0] e,
        logic [2:0] s, logic ai, logic [2:0] ac, logic [9:0] ht);
        return {i, h, 10'h000, e, s, ai, ac, ht, 2'b00};
    endfunction : ctl

    always @(posedge mclk) begin
        if (ndreset === 1'b1) nd_seen++;
        if (fullreset === 1'b1) fr_seen++;
        if (rst === 1'b0 && (lock_req.valid !== 1'b0 || lock_int !== '0 ||
            lock_nd !== 1'b0 || lock_fr !== 1'b0 || lock_txv !== 8'h00 ||
            lock_rxr !== 8'h00)) lock_seen++;
    end

    initial begin
        forever #4 mclk = ~mclk;
    end

    initial begin
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        xfer(0, A_CTRL, 0);
        check(rd, ctl(0, 0, 0, 0, 0, ACC_RST, 0));
        xfer(1, A_CTRL, ctl(1, 0, 0, 3, 0, ACC_RST, 5) | 34'h0_ffc0_0000);
        xfer(0, A_CTRL, 0);
        check(rd, ctl(1, 0, 0, 3, 0, ACC_RST, 5));
        check(dbg_int[5], 1'b1);
        @(posedge mclk) #1 sethalt = '{1'b1, 10'h005};
        @(posedge mclk) #1 sethalt.valid = 1'b0;
        clrint = '{1'b1, 10'h005};
        @(posedge mclk) #1 clrint.valid = 1'b0;
        @(posedge mclk) #1;
        check(dbg_int[5], 1'b0);
        dreq = '{1'b1, 1'b1, A_CTRL, ctl(1, 1, 0, 3, 0, ACC_RST, 5)};
        clrint = '{1'b1, 10'h005};
        @(posedge mclk) #1 clrint.valid = 1'b0;
        dreq.valid = 1'b0;
        check(dbg_int[5], 1'b1);
        xfer(0, A_CTRL, 0);
        check(rd[C_HALT], 1'b1);
        xfer(1, A_CTRL, ctl(0, 0, 0, 3, 0, ACC_RST, 5));
        xfer(0, A_CTRL, 0);
        check(rd[C_HALT], 1'b0);
        xfer(1, A_SDATA, {2'b10, 32'h5a5a_0003});
        check(tx_v[3], 1'b1);
        check(tx_d[3], 32'h5a5a_0003);
        xfer(0, A_SDATA, 0);
        check(rd, {2'b01, 32'h0000_0000});
        @(posedge mclk) #1 tx_rdy = 8'h08;
        rx_v = 8'h08;
        rx_w = 32'h0bad_f00d;
        @(posedge mclk) #1 tx_rdy = 8'h00;
        rx_v = 8'h00;
        check(tx_v[3], 1'b0);
        check(rx_rdy[3], 1'b0);
        xfer(0, A_SDATA, 0);
        check(rd, {2'b10, 32'h0bad_f00d});
        check(rx_rdy[3], 1'b1);
        xfer(0, 7'h1a, 0);
        check(rd, 0);
        // bus read through all three address slices
        xfer(1, A_SBA1, 34'h1);
        xfer(1, A_SBA2, 34'h2);
        xfer(1, A_SBA0, 34'h100);
        wait_sb();
        check(last_addr, {32'h2, 32'h1, 32'h100});
        xfer(0, A_SBD0, 0);
        check(rd[31:0], 32'hc0de_0100);
        xfer(1, A_CTRL, ctl(0, 0, 0, 3, 1, ACC_RST, 5));
        xfer(1, A_SBA0, 34'h200);
        wait_sb();
        xfer(1, A_SBD0, 34'h77);
        wait_sb();
        check(last_addr[31:0], 32'h204);
        err_code = ERR_BADADDR;
        xfer(1, A_SBA0, 34'h300);
        wait_sb();
        xfer(0, A_CTRL, 0);
        check(rd[C_ERR_HI:C_ERR_LO], ERR_BADADDR);
        xfer(1, A_SBA0, 34'h400);
        repeat (10) @(posedge mclk) #1;
        check(last_addr[31:0], 32'h300);
        xfer(1, A_SBD0, 34'h99);
        xfer(0, A_SBD0, 0);
        check(rd[31:0], 32'h77);
        err_code = ERR_NONE;
        xfer(1, A_CTRL, ctl(0, 0, 0, 3, 0, 3'h5, 5));
        xfer(0, A_CTRL, 0);
        check(rd[C_ERR_HI:C_ERR_LO], ERR_NONE);
        xfer(1, A_SBA0, 34'h500);
        repeat (4) @(posedge mclk);
        xfer(0, A_CTRL, 0);
        check(rd[C_ERR_HI:C_ERR_LO], ERR_OTHER);
        check(last_addr[31:0], 32'h300);
        xfer(1, A_CTRL, ctl(0, 0, 0, 3, 0, ACC_RST, 5));
        mute = 1'b1;
        xfer(1, A_SBA0, 34'h600);
        repeat (12) @(posedge mclk);
        xfer(0, A_CTRL, 0);
        check(rd[C_ERR_HI:C_ERR_LO], ERR_TIMEOUT);
        xfer(1, A_CTRL, ctl(0, 0, 0, 3, 0, ACC_RST, 5) | 34'h2);
        repeat (3) @(posedge mclk);
        check(nd_seen, 1);
        // the full reset also clears the answer pipeline, so no answer
        @(posedge mclk) #1 dreq = '{1'b1, 1'b1, A_CTRL,
                                    ctl(1, 0, 0, 3, 0, ACC_RST, 5) | 34'h1};
        @(posedge mclk) #1 dreq.valid = 1'b0;
        repeat (3) @(posedge mclk);
        check(fr_seen, 1);
        xfer(0, A_CTRL, 0);
        check(rd, ctl(0, 0, 0, 0, 0, ACC_RST, 0));
        check(dbg_int[5], 1'b0);
        check(lock_seen, 0);
        xfer(0, A_INFO, 0);
        check(lock_data[5], 1'b0);
        check(rd[5], 1'b1);
        xfer(1, A_AUTH1, 34'h1);
        xfer(1, A_AUTH0, 34'h2);
        xfer(0, A_INFO, 0);
        check(lock_data[5], 1'b1);
        report_and_stop();
    end
endmodule : dbgreg_ctrl_tb
